/* hdl/gsn_regs.v */
// global status flags, serial write counter and node configuration
// assumes the serial front end presents decoded register accesses on the
// access port, one cycle per access, and all inputs are synchronous to mclk
`timescale 1ns/1ps
`include "gsn_defs.vh"

module gsn_regs (
  input  wire                mclk,
  input  wire                arst_n,
  input  wire                acc_valid,
  input  wire                acc_write,
  input  wire [`GSN_AW-1:0]  acc_addr,
  input  wire [`GSN_DW-1:0]  acc_wdata,
  input  wire                acc_uart,
  input  wire                spi_mode,
  input  wire                drv1_fault,
  input  wire                drv2_fault,
  input  wire                pump_uv,
  input  wire                nextaddr_pin,
  input  wire                ring_mode,
  input  wire                bit_tick,
  input  wire                read_req_done,
  output reg  [`GSN_DW-1:0]  acc_rdata,
  output reg                 acc_rdata_valid,
  output reg  [7:0]          node_address,
  output reg                 forward_enable,
  output reg                 drive_stage_enable,
  output wire [3:0]          reply_delay_select,
  output wire                reply_start,
  output wire                reply_busy
);

  // ****************************************
  // access decode
  // ****************************************
  wire rd_any;
  wire wr_any;
  wire rd_status;
  wire rd_wrcnt;
  wire wr_nodecfg;
  wire count_write;

  assign rd_any     = acc_valid & ~acc_write;
  assign wr_any     = acc_valid & acc_write;
  assign rd_status  = rd_any & (acc_addr == `GSN_ADR_STATUS);
  assign rd_wrcnt   = rd_any & (acc_addr == `GSN_ADR_WRCNT);
  assign wr_nodecfg = wr_any & (acc_addr == `GSN_ADR_NODECFG);
  // only writes arriving over the single-wire link are counted
  assign count_write = wr_any & acc_uart & ~spi_mode;

  // ****************************************
  // status flags
  // ****************************************
  reg  [`GSN_ST_W-1:0] global_status_flags;
  wire [`GSN_ST_W-1:0] next_status;
  wire [`GSN_ST_W-1:0] cause;

  assign cause[`GSN_ST_RESET] = 1'b0;
  assign cause[`GSN_ST_DRV1]  = drv1_fault;
  assign cause[`GSN_ST_DRV2]  = drv2_fault;
  assign cause[`GSN_ST_PUMP]  = pump_uv;

  // the reset flag has no live cause: only the reset sets it
  assign next_status[`GSN_ST_RESET] =
    rd_status ? 1'b0 : global_status_flags[`GSN_ST_RESET];

  // a read clears a flag only when its cause is gone, and a cause
  // present in the read cycle keeps the flag set
  genvar gi;
  generate
    for (gi = `GSN_ST_DRV1; gi < `GSN_ST_W; gi = gi + 1) begin : g_flag
      assign next_status[gi] = cause[gi] |
        (global_status_flags[gi] & ~rd_status);
    end
  endgenerate

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      global_status_flags <= `GSN_ST_RST_VAL;
    end else begin
      global_status_flags <= next_status;
    end
  end

  // ****************************************
  // serial write counter
  // ****************************************
  reg  [7:0] uart_write_counter;
  wire [7:0] next_counter;

  // eight-bit add wraps 255 to 0 by itself
  assign next_counter = count_write ?
    uart_write_counter + `GSN_CNT_ONE :
    uart_write_counter;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      uart_write_counter <= `GSN_CNT_RST;
    end else begin
      uart_write_counter <= next_counter;
    end
  end

  // ****************************************
  // node configuration
  // ****************************************
  reg [7:0] cfg_addr;
  reg [3:0] cfg_delay;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_addr  <= `GSN_ADDR_RST;
      cfg_delay <= `GSN_DLY_RST;
    end else if (wr_nodecfg) begin
      cfg_addr  <= acc_wdata[`GSN_CFG_ADR_HI:`GSN_CFG_ADR_LO];
      cfg_delay <= acc_wdata[`GSN_CFG_DLY_HI:`GSN_CFG_DLY_LO];
    end
  end

  assign reply_delay_select = cfg_delay;

  // ****************************************
  // node address and forwarding
  // ****************************************
  wire [7:0] next_node_address;
  wire       next_forward;

  // no guard on 255: the host keeps the programmed value at 253 or less
  assign next_node_address = cfg_addr + {7'h00, nextaddr_pin};
  // forwarding keys on the programmed value, not the incremented one
  assign next_forward = ~(ring_mode &
                          (cfg_addr == `GSN_ADDR_ZERO));

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      node_address   <= `GSN_ADDR_RST;
      forward_enable <= 1'b0;
    end else begin
      node_address   <= next_node_address;
      forward_enable <= next_forward;
    end
  end

  // ****************************************
  // driver stage enable
  // ****************************************
  // held off from reset until the pump voltage is seen good
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      drive_stage_enable <= 1'b0;
    end else begin
      drive_stage_enable <= ~pump_uv;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  reg [`GSN_DW-1:0] next_rdata;

  // the status read returns the flags as held before the clear
  always @* begin
    next_rdata = `GSN_RDATA_RST;
    if (rd_status) begin
      next_rdata = {`GSN_ST_PAD, global_status_flags};
    end else if (rd_wrcnt) begin
      next_rdata = {`GSN_CNT_PAD, uart_write_counter};
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acc_rdata       <= `GSN_RDATA_RST;
      acc_rdata_valid <= 1'b0;
    end else begin
      acc_rdata_valid <= rd_any;
      if (rd_any) begin
        acc_rdata <= next_rdata;
      end
    end
  end

  // ****************************************
  // reply delay
  // ****************************************
  gsn_reply_delay u_delay (
    .mclk               (mclk),
    .arst_n             (arst_n),
    .reply_delay_select (cfg_delay),
    .bit_tick           (bit_tick),
    .read_req_done      (read_req_done),
    .reply_start        (reply_start),
    .reply_busy         (reply_busy)
  );

endmodule

/* hdl/gsn_defs.vh */
// constants for the global status and serial node configuration bank
// assumes inclusion by bare name from every design file of the bank
// Function
// - status bit 0 is set by any reset until status is read
// - status bit 1 latches a shutdown of the first driver
// - status bit 2 latches a shutdown of the second driver
// - a shutdown flag survives a read while its fault persists
// - status bit 3 shows pump undervoltage; drivers held off meanwhile
// - four-bit status at 0x01 holds until read, then clears ended causes
// - eight-bit counter at 0x02 counts each successful serial write
// - reading the write counter leaves it unchanged
// - the write counter stays still in the four-wire mode
// - the write counter wraps from 255 to 0
// - config bits 7..0 set node address, reset 0; host uses 0..253
// - the next-address pin adds one to the node address
// - in ring mode a programmed address of 0 stops forwarding
// - config bits 11..8 pick reply delay: pairs give 8,24,...,120 bits
`ifndef GSN_DEFS_VH
`define GSN_DEFS_VH

// ****************************************
// access port
// ****************************************
`define GSN_AW          7
`define GSN_DW          32
`define GSN_ADR_STATUS  7'h01
`define GSN_ADR_WRCNT   7'h02
`define GSN_ADR_NODECFG 7'h03
`define GSN_RDATA_RST   32'h00000000

// ****************************************
// status flags
// ****************************************
`define GSN_ST_W        4
`define GSN_ST_RESET    0
`define GSN_ST_DRV1     1
`define GSN_ST_DRV2     2
`define GSN_ST_PUMP     3
`define GSN_ST_RST_VAL  4'h1

// ****************************************
// write counter and node configuration
// ****************************************
`define GSN_CNT_RST     8'h00
`define GSN_CNT_ONE     8'h01
`define GSN_ADDR_RST    8'h00
`define GSN_ADDR_ZERO   8'h00
`define GSN_DLY_RST     4'h0
`define GSN_CFG_ADR_HI  7
`define GSN_CFG_ADR_LO  0
`define GSN_CFG_DLY_HI  11
`define GSN_CFG_DLY_LO  8
`define GSN_ST_PAD      28'h0000000
`define GSN_CNT_PAD     24'h000000

// ****************************************
// reply delay: odd multiple of eight bit times
// ****************************************
`define GSN_DLY_CW      7
`define GSN_DLY_ODD     1'h1
`define GSN_DLY_X8      3'h0
`define GSN_DLY_LAST    7'h01
`define GSN_DLY_CNT_RST 7'h00

`endif

/* hdl/gsn_reply_delay.v */
// reply delay timer: counts bit ticks between read request and reply
// assumes bit_tick is a one-cycle pulse per serial bit time
`timescale 1ns/1ps
`include "gsn_defs.vh"

module gsn_reply_delay (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire [3:0] reply_delay_select,
  input  wire       bit_tick,
  input  wire       read_req_done,
  output reg        reply_start,
  output wire       reply_busy
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg                    state;
  reg                    next_state;
  reg [`GSN_DLY_CW-1:0]  count;
  reg [`GSN_DLY_CW-1:0]  next_count;
  reg                    next_start;
  wire [`GSN_DLY_CW-1:0] target;

  // pair 2k,2k+1 maps to (2k+1)*8 bit times
  assign target = {reply_delay_select[3:1], `GSN_DLY_ODD,
                   `GSN_DLY_X8};
  assign reply_busy = (state == ST_WAIT);

  always @* begin
    next_state = state;
    next_count = count;
    next_start = 1'b0;
    case (state)
      ST_IDLE: begin
        if (read_req_done) begin
          next_state = ST_WAIT;
          next_count = target;
        end
      end
      ST_WAIT: begin
        // a fresh request restarts the wait rather than queueing
        if (read_req_done) begin
          next_count = target;
        end else if (bit_tick) begin
          if (count == `GSN_DLY_LAST) begin
            next_state = ST_IDLE;
            next_start = 1'b1;
          end else begin
            next_count = count - `GSN_DLY_LAST;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_count = `GSN_DLY_CNT_RST;
      end
    endcase
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= ST_IDLE;
      count       <= `GSN_DLY_CNT_RST;
      reply_start <= 1'b0;
    end else begin
      state       <= next_state;
      count       <= next_count;
      reply_start <= next_start;
    end
  end

endmodule

/* test/gsn_tick_src.sv */
// bit-time tick source standing in for the serial front end
// assumes tick_en is driven off the rising edge by the bench
`timescale 1ns/1ps

module gsn_tick_src (
  input  wire mclk,
  input  wire arst_n,
  input  wire tick_en,
  output reg  bit_tick
);
  reg [1:0] div;

  // ticks stop outside a reply wait, so stale ticks cannot count
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div <= 2'h0;
      bit_tick <= 1'b0;
    end else begin
      div <= tick_en ? div + 2'h1 : 2'h0;
      bit_tick <= tick_en && div == 2'h3;
    end
  end
endmodule

/* test/gsn_regs_sva.sv */
// checker for the status and node configuration bank
// assumes it is bound onto gsn_regs and sees its ports only
`timescale 1ns/1ps
`include "gsn_defs.vh"

module gsn_regs_chk (
  input wire               mclk,
  input wire               arst_n,
  input wire               acc_valid,
  input wire               acc_write,
  input wire [`GSN_AW-1:0] acc_addr,
  input wire               drv1_fault,
  input wire               drv2_fault,
  input wire               pump_uv,
  input wire               read_req_done,
  input wire [`GSN_DW-1:0] acc_rdata,
  input wire               acc_rdata_valid,
  input wire               drive_stage_enable,
  input wire               reply_start,
  input wire               reply_busy
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire st_rd = acc_valid && !acc_write && acc_addr == `GSN_ADR_STATUS;

  a_read_answer:
    assert property (acc_valid && !acc_write |=> acc_rdata_valid)
      else $error("read without answer");
  a_write_silent:
    assert property (acc_valid && acc_write |=> !acc_rdata_valid)
      else $error("write gave an answer");
  a_drv1_flag:
    assert property (st_rd && drv1_fault && $past(drv1_fault)
      |=> acc_rdata[1]) else $error("driver one flag missing");
  a_drv2_flag:
    assert property (st_rd && drv2_fault && $past(drv2_fault)
      |=> acc_rdata[2]) else $error("driver two flag missing");
  a_pump_flag:
    assert property (st_rd && pump_uv && $past(pump_uv)
      |=> acc_rdata[3]) else $error("pump flag missing");
  a_drive_off:
    assert property (pump_uv |=> !drive_stage_enable)
      else $error("drivers on during undervoltage");
  a_busy_start:
    assert property (read_req_done |=> reply_busy)
      else $error("delay did not start");
  a_reply_end:
    assert property ($rose(reply_start) |-> !reply_busy && $past(reply_busy)
      ##1 !reply_start) else $error("reply start malformed");

  c_pump_read: cover property (st_rd && pump_uv);
  c_request: cover property (read_req_done);
  c_reply: cover property ($rose(reply_start));
endmodule

bind gsn_regs gsn_regs_chk u_chk (.mclk, .arst_n, .acc_valid, .acc_write,
  .acc_addr, .drv1_fault, .drv2_fault, .pump_uv, .read_req_done, .acc_rdata,
  .acc_rdata_valid, .drive_stage_enable, .reply_start, .reply_busy);

/* test/testbench.sv */
// bench for the status and node configuration bank
// assumes gsn_regs, its checker and the tick source are compiled first
`timescale 1ns/1ps

module testbench;
  reg         mclk = 1'b0, arst_n = 1'b0, acc_valid = 1'b0;
  reg         acc_write = 1'b0, acc_uart = 1'b0, spi_mode = 1'b0;
  reg         drv1_fault = 1'b0, drv2_fault = 1'b0, pump_uv = 1'b0;
  reg         nextaddr_pin = 1'b0, ring_mode = 1'b0, tick_en = 1'b0;
  reg         read_req_done = 1'b0;
  reg  [6:0]  acc_addr = 7'h00;
  reg  [31:0] acc_wdata = 32'h0;
  wire [31:0] acc_rdata;
  wire [7:0]  node_address;
  wire [3:0]  reply_delay_select;
  wire        acc_rdata_valid, forward_enable, drive_stage_enable;
  wire        reply_start, reply_busy, bit_tick;
  integer     fails = 0, tests_run = 0, k;

  gsn_regs dut (.mclk, .arst_n, .acc_valid, .acc_write, .acc_addr,
    .acc_wdata, .acc_uart, .spi_mode, .drv1_fault, .drv2_fault, .pump_uv,
    .nextaddr_pin, .ring_mode, .bit_tick, .read_req_done, .acc_rdata,
    .acc_rdata_valid, .node_address, .forward_enable, .drive_stage_enable,
    .reply_delay_select, .reply_start, .reply_busy);
  gsn_tick_src host (.mclk, .arst_n, .tick_en, .bit_tick);

  initial forever #50 mclk = ~mclk;

  // ****************
  // access tasks
  // ****************
  task test_done;
    begin
      if (fails == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task give_up;
    begin
      fails = fails + 1;
      test_done;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] want);
    begin
      tests_run = tests_run + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("Error at %0t: got %h want %h", $time, seen, want);
      end
    end
  endtask
  task wr(input [6:0] a, input [31:0] v, input u, input s);
    begin
      @(negedge mclk);
      acc_valid = 1'b1;
      acc_write = 1'b1;
      acc_addr = a;
      acc_wdata = v;
      acc_uart = u;
      spi_mode = s;
      @(negedge mclk);
      acc_valid = 1'b0;
      acc_uart = 1'b0;
    end
  endtask
  task rchk(input [6:0] a, input [31:0] want);
    integer i;
    begin
      @(negedge mclk);
      acc_valid = 1'b1;
      acc_write = 1'b0;
      acc_addr = a;
      @(negedge mclk);
      acc_valid = 1'b0;
      for (i = 0; i < 4 && acc_rdata_valid !== 1'b1; i = i + 1)
        @(negedge mclk);
      if (i == 4)
        give_up;
      chk(acc_rdata, want);
    end
  endtask
  // pairs of select codes share one odd multiple of eight bit times
  task dly(input [3:0] s);
    integer i, n;
    begin
      wr(7'h03, {20'h0, s, 8'h00}, 1'b0, 1'b0);
      @(negedge mclk);
      read_req_done = 1'b1;
      tick_en = 1'b1;
      @(negedge mclk);
      read_req_done = 1'b0;
      chk(reply_busy, 1'b1);
      n = 0;
      for (i = 0; i < 2000 && reply_start !== 1'b1; i = i + 1) begin
        if (bit_tick === 1'b1)
          n = n + 1;
        @(negedge mclk);
      end
      tick_en = 1'b0;
      if (i == 2000)
        give_up;
      chk(n, (s | 4'h1) * 8);
    end
  endtask

  initial begin
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    rchk(7'h01, 32'h1);
    rchk(7'h01, 32'h0);
    drv1_fault = 1'b1;
    rchk(7'h01, 32'h2);
    rchk(7'h01, 32'h2);
    drv1_fault = 1'b0;
    drv2_fault = 1'b1;
    pump_uv = 1'b1;
    rchk(7'h01, 32'hE);
    chk(drive_stage_enable, 1'b0);
    drv2_fault = 1'b0;
    pump_uv = 1'b0;
    rchk(7'h01, 32'hC);
    rchk(7'h01, 32'h0);
    chk(drive_stage_enable, 1'b1);
    for (k = 0; k < 3; k = k + 1)
      wr(7'h03, 32'h0, 1'b1, 1'b0);
    rchk(7'h02, 32'h3);
    rchk(7'h02, 32'h3);
    wr(7'h03, 32'h0, 1'b1, 1'b1);
    wr(7'h03, 32'h0, 1'b0, 1'b0);
    rchk(7'h02, 32'h3);
    for (k = 0; k < 253; k = k + 1)
      wr(7'h03, 32'h0, 1'b1, 1'b0);
    rchk(7'h02, 32'h0);
    ring_mode = 1'b1;
    wr(7'h03, 32'h305, 1'b1, 1'b0);
    repeat (3) @(negedge mclk);
    chk(node_address, 8'h05);
    chk(reply_delay_select, 4'h3);
    chk(forward_enable, 1'b1);
    nextaddr_pin = 1'b1;
    repeat (2) @(negedge mclk);
    chk(node_address, 8'h06);
    wr(7'h03, 32'hFD, 1'b1, 1'b0);
    repeat (3) @(negedge mclk);
    chk(node_address, 8'hFE);
    wr(7'h03, 32'h0, 1'b1, 1'b0);
    repeat (3) @(negedge mclk);
    chk(forward_enable, 1'b0);
    chk(node_address, 8'h01);
    nextaddr_pin = 1'b0;
    ring_mode = 1'b0;
    rchk(7'h03, 32'h0);
    rchk(7'h05, 32'h0);
    // mid-run reset must bring back the reset flag and clear the rest
    @(negedge mclk);
    arst_n = 1'b0;
    @(negedge mclk);
    arst_n = 1'b1;
    rchk(7'h01, 32'h1);
    rchk(7'h02, 32'h0);
    chk(node_address, 8'h00);
    chk(reply_delay_select, 4'h0);
    for (k = 0; k < 16; k = k + 1)
      dly(k[3:0]);
    test_done;
  end
endmodule
